// >>> logic/mpw_unit.sv
`timescale 1ns/1ps
// Functional notes
// - Counter of prescaler ticks compared with seven match registers, events flagged.
// - Only the pulse outputs leave the block as pins.
// - Cycle match resets the counter and sets the common period.
// - Single-edge output uses cycle match plus one edge match register.
// - Each further single-edge output needs just one more match register.
// - Single-edge outputs rise at cycle start unless held constantly low.
// - Double-edge output uses cycle match plus separate rise and fall matches.
// - Each further double-edge output needs two more match registers.
// - Rise before fall gives a high pulse up to fall, fall first gives high from rise to cycle end.
// - Double-edge rise and fall may sit anywhere in the cycle.
// - Seven matches give six single, three double, or any mix.
// - Any match may let the counter run on, optional event flag.
// - Any match may halt the counter, optional event flag.
// - Any match may clear the counter, optional event flag.
// - Period and width are any whole number of ticks.
// - In pulse mode match updates take effect only at the period boundary.
// - With pulse mode off the unit is a plain timer.
// - Counter and prescaler are both 32 bits wide.
module mpw_unit #(
  parameter int NM = mpw_pkg::NUM_MATCH,
  parameter int NO = mpw_pkg::NUM_OUT,
  parameter int CW = mpw_pkg::CNT_W,
  parameter int PW = mpw_pkg::PRE_W
) (
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic                 cnt_enable,
  input  wire logic                 cnt_clear,
  input  wire logic                 pwm_mode,
  input  wire logic [PW-1:0]        prescale_limit,
  input  wire logic [NM*CW-1:0]     match_wdata,
  input  wire logic [NM-1:0]        match_write,
  input  wire logic [NM-1:0]        match_release,
  input  wire logic [NM*3-1:0]      match_ctrl,
  input  wire logic [NO-1:0]        out_enable,
  input  wire logic [NO-1:0]        out_double,
  input  wire logic [NM-1:0]        flag_clear,
  output logic      [CW-1:0]        count_value,
  output logic      [PW-1:0]        prescale_value,
  output logic      [NM-1:0]        match_flag,
  output logic                      halted,
  output logic      [NO-1:0]        pwm_out
);
  mpw_pkg::mpw_state_t state_q;
  mpw_pkg::mpw_state_t state_d;
  logic [CW-1:0]       cnt_q;
  logic [CW-1:0]       cnt_d;
  logic [CW-1:0]       hold_q   [NM];
  logic [CW-1:0]       hold_d   [NM];
  logic [CW-1:0]       act_q    [NM];
  logic [CW-1:0]       act_d    [NM];
  logic [NM-1:0]       pend_q;
  logic [NM-1:0]       pend_d;
  logic [NM-1:0]       flag_q;
  logic [NM-1:0]       flag_d;
  logic [NO-1:0]       out_q;
  logic [NO-1:0]       out_d;
  logic [NM-1:0]       hit;
  logic                tick;
  logic                run;
  logic                cyc_hit;
  logic [NM-1:0]       ctl_flag;
  logic [NM-1:0]       ctl_clr;
  logic [NM-1:0]       ctl_stop;

  // One bit of the three-bit match control field of one match register
  function automatic logic ctrl_bit(input logic [NM*3-1:0] c, input int idx, input int pos);
    ctrl_bit = c[idx*mpw_pkg::MC_W + pos];
  endfunction

  // Control field decode per match register
  always_comb
  begin
    for (int i = 0; i < NM; i++)
    begin
      ctl_flag[i] = ctrl_bit(match_ctrl, i, mpw_pkg::MC_INT_BIT);
      ctl_clr[i]  = ctrl_bit(match_ctrl, i, mpw_pkg::MC_RST_BIT);
      ctl_stop[i] = ctrl_bit(match_ctrl, i, mpw_pkg::MC_STOP_BIT);
    end
  end

  assign run = (state_q == mpw_pkg::MPW_RUN);

  // Prescaler feeding the counter
  mpw_prescaler #(
    .W (PW)
  ) u_pre (
    .mclk  (mclk),
    .rst_n (rst_n),
    .run   (run),
    .clr   (cnt_clear),
    .limit (prescale_limit),
    .tick  (tick),
    .count (prescale_value)
  );

  // Comparators against the active match values
  always_comb
  begin
    for (int i = 0; i < NM; i++)
      hit[i] = tick && (cnt_q == act_q[i]);
    cyc_hit = hit[mpw_pkg::CYCLE_IDX];
  end

  // Next counter value and run state
  always_comb
  begin
    logic rst_hit;
    logic stop_hit;
    rst_hit  = 1'b0;
    stop_hit = 1'b0;
    for (int i = 0; i < NM; i++)
    begin
      rst_hit  = rst_hit | (hit[i] & ctl_clr[i]);
      stop_hit = stop_hit | (hit[i] & ctl_stop[i]);
    end
    // In pulse mode the cycle match always bounds the period
    if (pwm_mode && cyc_hit)
      rst_hit = 1'b1;
    cnt_d   = cnt_q;
    state_d = state_q;
    case (state_q)
      mpw_pkg::MPW_IDLE:
      begin
        if (cnt_enable)
          state_d = mpw_pkg::MPW_RUN;
      end
      mpw_pkg::MPW_RUN:
      begin
        if (!cnt_enable)
          state_d = mpw_pkg::MPW_IDLE;
        else if (stop_hit)
          state_d = mpw_pkg::MPW_HALT;
        if (rst_hit)
          cnt_d = '0;
        else if (tick && !stop_hit)    // Stays on a stop match
          cnt_d = cnt_q + CW'(1);
      end
      mpw_pkg::MPW_HALT:
      begin
        if (!cnt_enable)
          state_d = mpw_pkg::MPW_IDLE;
      end
      default:
        state_d = mpw_pkg::MPW_IDLE;
    endcase
    if (cnt_clear)
      cnt_d = '0;
  end

  // Counter and state registers
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cnt_q   <= mpw_pkg::CNT_RST;
      state_q <= mpw_pkg::MPW_IDLE;
    end
    else
    begin
      cnt_q   <= cnt_d;
      state_q <= state_d;
    end
  end

  // Holding registers, release flags and shadow transfer
  always_comb
  begin
    for (int i = 0; i < NM; i++)
    begin
      hold_d[i] = hold_q[i];
      act_d[i]  = act_q[i];
      pend_d[i] = pend_q[i];
      if (match_write[i])
      begin
        hold_d[i] = match_wdata[i*CW +: CW];
        pend_d[i] = 1'b0;
      end
      if (match_release[i])
        pend_d[i] = 1'b1;
      if (!pwm_mode)
      begin
        // Plain timer: written values act at once
        if (match_write[i])
          act_d[i] = match_wdata[i*CW +: CW];
        pend_d[i] = 1'b0;
      end
      else if (cyc_hit && pend_q[i])
      begin
        act_d[i] = hold_q[i];
        if (!match_release[i])
          pend_d[i] = 1'b0;
      end
    end
  end

  // Match value registers
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NM; i++)
      begin
        hold_q[i] <= mpw_pkg::MATCH_RST;
        act_q[i]  <= mpw_pkg::MATCH_RST;
      end
      pend_q <= '0;
    end
    else
    begin
      hold_q <= hold_d;
      act_q  <= act_d;
      pend_q <= pend_d;
    end
  end

  // Sticky match event flags, set wins over clear
  always_comb
  begin
    for (int i = 0; i < NM; i++)
      flag_d[i] = (flag_q[i] & ~flag_clear[i])
                | (hit[i] & ctl_flag[i]);
  end

  // Pulse outputs, output n uses match n+1 for its edge
  always_comb
  begin
    out_d = out_q;
    for (int n = 0; n < NO; n++)
    begin
      if (!pwm_mode || !out_enable[n])
        out_d[n] = 1'b0;
      else if (out_double[n] && n >= 1)
      begin
        // Double edge: rise on match n, fall on match n+1
        if (hit[n + 1])
          out_d[n] = 1'b0;
        else if (hit[n])
          out_d[n] = 1'b1;
        else if (cyc_hit)
          out_d[n] = 1'b0;
      end
      else
      begin
        // Single edge: high at cycle start, low at its own match
        if (hit[n + 1])
          out_d[n] = 1'b0;
        else if (cyc_hit)
          out_d[n] = 1'b1;
      end
    end
  end

  // Flag and output registers
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      flag_q <= '0;
      out_q  <= '0;
    end
    else
    begin
      flag_q <= flag_d;
      out_q  <= out_d;
    end
  end

  assign count_value = cnt_q;
  assign match_flag  = flag_q;
  assign halted      = (state_q == mpw_pkg::MPW_HALT);
  assign pwm_out     = out_q;
endmodule

// >>> include/mpw_pkg.sv
package mpw_pkg;
  // Match register count and widths
  localparam int NUM_MATCH   = 7;
  localparam int NUM_OUT     = 6;
  localparam int CNT_W       = 32;
  localparam int PRE_W       = 32;
  // Index of the cycle match register
  localparam int CYCLE_IDX   = 0;
  // Match control field positions, three bits per match register
  localparam int MC_INT_BIT  = 0;
  localparam int MC_RST_BIT  = 1;
  localparam int MC_STOP_BIT = 2;
  localparam int MC_W        = 3;
  // Reset values
  localparam logic [31:0] CNT_RST   = 32'h0000_0000;
  localparam logic [31:0] PRE_RST   = 32'h0000_0000;
  localparam logic [31:0] MATCH_RST = 32'h0000_0000;
  // Run state of the counter
  typedef enum logic [1:0] {
    MPW_IDLE = 2'b00,
    MPW_RUN  = 2'b01,
    MPW_HALT = 2'b10
  } mpw_state_t;
endpackage

// >>> logic/mpw_prescaler.sv
`timescale 1ns/1ps
// Prescaler: one-cycle tick each time the count reaches its limit
module mpw_prescaler #(
  parameter int W = 32
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         run,
  input  wire logic         clr,
  input  wire logic [W-1:0] limit,
  output logic              tick,
  output logic [W-1:0]      count
);
  logic [W-1:0] count_q;
  logic [W-1:0] count_d;

  // Next prescale count, wraps to zero at the limit
  always_comb
  begin
    count_d = count_q;
    tick    = 1'b0;
    if (clr)
      count_d = '0;
    else if (run)
    begin
      if (count_q >= limit)
      begin
        count_d = '0;
        tick    = 1'b1;
      end
      else
        count_d = count_q + W'(1);
    end
  end

  // Register the prescale count
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      count_q <= '0;
    else
      count_q <= count_d;
  end

  assign count = count_q;
endmodule

// >>> verification/mpw_unit_props.sv
`timescale 1ns/1ps
// Port-level checker for the pulse unit
module mpw_unit_props #(
  parameter int NM = 7,
  parameter int NO = 6,
  parameter int CW = 32,
  parameter int PW = 32
) (
  input wire logic             mclk,
  input wire logic             rst_n,
  input wire logic             cnt_enable,
  input wire logic             cnt_clear,
  input wire logic             pwm_mode,
  input wire logic [PW-1:0]    prescale_limit,
  input wire logic [NM*3-1:0]  match_ctrl,
  input wire logic [NO-1:0]    out_enable,
  input wire logic [NM-1:0]    flag_clear,
  input wire logic [CW-1:0]    count_value,
  input wire logic [PW-1:0]    prescale_value,
  input wire logic [NM-1:0]    match_flag,
  input wire logic             halted,
  input wire logic [NO-1:0]    pwm_out
);
  logic [NM-1:0] fen;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // Flag enable bits gathered from the control field
  always_comb
  begin
    for (int i = 0; i < NM; i++)
      fen[i] = match_ctrl[i*3+mpw_pkg::MC_INT_BIT];
  end
  property p_off;
    !pwm_mode |=> pwm_out == '0;
  endproperty
  a_off: assert property (p_off) else $error("output active in timer mode");
  property p_dis;
    $past(rst_n) |-> (pwm_out & ~$past(out_enable)) == '0;
  endproperty
  a_dis: assert property (p_dis) else $error("disabled output high");
  property p_hold;
    halted && $past(halted) && !$past(cnt_clear) |-> $stable(count_value);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved while halted");
  property p_leave;
    !cnt_enable |=> !halted;
  endproperty
  a_leave: assert property (p_leave) else $error("halt kept while disabled");
  property p_clr;
    cnt_clear |=> count_value == '0 && prescale_value == '0;
  endproperty
  a_clr: assert property (p_clr) else $error("clear ignored");
  property p_sticky;
    $past(rst_n) |-> ($past(match_flag) & ~$past(flag_clear) & ~match_flag) == '0;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");
  property p_flag_en;
    $past(rst_n) |-> (match_flag & ~$past(match_flag) & ~$past(fen)) == '0;
  endproperty
  a_flag_en: assert property (p_flag_en) else $error("flag set while off");
  property p_wrap;
    cnt_enable && $past(cnt_enable) && !cnt_clear && !halted
      && prescale_value == prescale_limit |=> prescale_value == '0 || halted;
  endproperty
  a_wrap: assert property (p_wrap) else $error("prescaler did not wrap");
endmodule

bind mpw_unit mpw_unit_props #(.NM(NM), .NO(NO), .CW(CW), .PW(PW)) u_props (.mclk, .rst_n,
  .cnt_enable, .cnt_clear, .pwm_mode, .prescale_limit, .match_ctrl, .out_enable,
  .flag_clear, .count_value, .prescale_value, .match_flag, .halted, .pwm_out);

// >>> verification/mpw_drive_stage.sv
`timescale 1ns/1ps
// Gate driver stand-in: counts turn-on edges of one channel
module mpw_drive_stage (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        gate,
  output logic      [31:0] rises
);
  logic gate_q;
  // Edge detect and count
  always_ff @(posedge mclk)
  begin
    gate_q <= gate;
    if (!rst_n)
      rises <= '0;
    else if (gate && !gate_q)
      rises <= rises + 32'h1;
  end
endmodule

// >>> verification/mpw_unit_tb_top.sv
`timescale 1ns/1ps
module mpw_unit_tb_top;
  logic         mclk;
  logic         rst_n;
  logic         cnt_enable;
  logic         cnt_clear;
  logic         pwm_mode;
  logic [31:0]  prescale_limit;
  logic [223:0] match_wdata;
  logic [6:0]   match_write;
  logic [6:0]   match_release;
  logic [20:0]  match_ctrl;
  logic [5:0]   out_enable;
  logic [5:0]   out_double;
  logic [6:0]   flag_clear;
  logic [31:0]  count_value;
  logic [31:0]  prescale_value;
  logic [6:0]   match_flag;
  logic         halted;
  logic [5:0]   pwm_out;
  logic [31:0]  rises;
  logic [5:0]   mo;
  int           mismatches, cmp_count, cycles, mc, rc, m[7], hd[7];
  bit           rl[7];

  mpw_unit dut (.mclk, .rst_n, .cnt_enable, .cnt_clear, .pwm_mode, .prescale_limit,
    .match_wdata, .match_write, .match_release, .match_ctrl, .out_enable, .out_double,
    .flag_clear, .count_value, .prescale_value, .match_flag, .halted, .pwm_out);
  mpw_drive_stage stage (.mclk, .rst_n, .gate(pwm_out[0]), .rises);

  // Clock
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Hang guard
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles > 1000)
    begin
      mismatches++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (mismatches == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One pulse-mode clock: drive match write and release, step the reference, compare
  task automatic tick(input int wi, input int wv, input int ri);
    bit h[3];
    match_write = (wi >= 0) ? 7'h01 << wi : 7'h00;
    match_release = (ri >= 0) ? 7'h01 << ri : 7'h00;
    if (wi >= 0)
      match_wdata[wi*32+:32] = wv;
    for (int i = 0; i < 3; i++)
      h[i] = (mc == m[i]);
    if (h[2])
      mo[1] = 1'b0;
    else if (h[1])
      mo[1] = 1'b1;
    else if (h[0])
      mo[1] = 1'b0;
    if (h[1])
      mo[0] = 1'b0;
    else if (h[0])
    begin
      mo[0] = 1'b1;
      rc++;
    end
    mc = h[0] ? 0 : mc + 1;
    for (int i = 0; i < 7; i++)
      if (h[0] && rl[i])
      begin
        m[i] = hd[i];
        rl[i] = 0;
      end
    if (wi >= 0)
    begin
      hd[wi] = wv;
      rl[wi] = 0;
    end
    if (ri >= 0)
      rl[ri] = 1;
    @(negedge mclk);
    chk(count_value, mc);
    chk(pwm_out, mo);
  endtask

  // Main sequence
  initial
  begin
    int p;
    rst_n = 1'b0;
    cnt_enable = 1'b0;
    cnt_clear = 1'b1;
    pwm_mode = 1'b0;
    prescale_limit = 32'h0;
    match_wdata = '0;
    match_write = 7'h00;
    match_release = 7'h00;
    match_ctrl = 21'h0;
    out_enable = 6'h03;
    out_double = 6'h02;
    flag_clear = 7'h00;
    mo = 6'h00;
    p = $urandom(73673);
    m[0] = 10 + $urandom % 6;
    m[1] = 1 + $urandom % 3;
    m[2] = 5 + $urandom % 3;
    for (int i = 0; i < 3; i++)
    begin
      hd[i] = m[i];
      match_wdata[i*32+:32] = m[i];
    end
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    match_write = 7'h7f;
    @(negedge mclk);
    cnt_clear = 1'b0;
    pwm_mode = 1'b1;
    cnt_enable = 1'b1;
    match_write = 7'h00;
    // Idle-to-run edge, counter still 0
    @(negedge mclk);
    repeat (2 * (m[0] + 1)) tick(-1, 0, -1);
    p = 8 + $urandom % 2;
    tick(1, p, -1);
    repeat (m[0] + 1) tick(-1, 0, -1);
    tick(-1, 0, 1);
    repeat (3 * (m[0] + 1)) tick(-1, 0, -1);
    // Timer mode with stop and flag on match 3
    pwm_mode = 1'b0;
    cnt_enable = 1'b0;
    cnt_clear = 1'b1;
    prescale_limit = $urandom % 3;
    match_ctrl[9+:3] = 3'h5;
    match_wdata[96+:32] = 32'h5;
    match_write = 7'h08;
    @(negedge mclk);
    chk(rises, rc);
    chk(pwm_out, 32'h0);
    match_write = 7'h00;
    cnt_clear = 1'b0;
    cnt_enable = 1'b1;
    repeat (30) @(negedge mclk);
    chk(halted, 32'h1);
    chk(count_value, 32'h5);
    chk(prescale_value, 32'h0);
    chk(match_flag, 32'h8);
    flag_clear = 7'h08;
    cnt_enable = 1'b0;
    @(negedge mclk);
    chk(match_flag, 32'h0);
    chk(halted, 32'h0);
    // Timer mode with counter clear on match 3
    flag_clear = 7'h00;
    match_ctrl[9+:3] = 3'h2;
    prescale_limit = 32'h0;
    cnt_clear = 1'b1;
    @(negedge mclk);
    cnt_clear = 1'b0;
    cnt_enable = 1'b1;
    repeat (8) @(negedge mclk);
    chk(count_value, 32'h1);
    chk(match_flag, 32'h0);
    chk(halted, 32'h0);
    finish_test();
  end
endmodule
